// ### verilog/wdsc_pkg.sv
// Package: constants and carrier types for the watchdog and sleep control
package wdsc_pkg;
  // Register offsets
  localparam logic [13:0] OPTION_ADDR  = 14'h0081;
  localparam logic [13:0] OPTION_ADDR2 = 14'h0181;
  localparam logic [13:0] CONFIG_ADDR  = 14'h2007;
  localparam logic [13:0] STATUS_ADDR  = 14'h0003;
  localparam logic [13:0] WAKEEN_ADDR  = 14'h0090;
  localparam logic [13:0] WAKEFLG_ADDR = 14'h0091;
  // Field positions
  localparam int CFG_WDT_ENABLE_FUSE_BIT  = 2;
  localparam int CFG_FOSC_LSB  = 0;
  localparam int OPT_PSA_BIT   = 3;
  localparam int OPT_RATE_LSB  = 0;
  localparam int OPT_RATE_W    = 3;
  localparam int STAT_PD_BIT   = 3;
  localparam int STAT_TO_BIT   = 4;
  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] CONFIG_RESET = 8'hff;
  localparam logic [7:0] WAKEEN_RESET = 8'h00;
  // Oscillator mode encoding of the two low config bits
  localparam logic [1:0] FOSC_RC = 2'h3;
  // Timing
  localparam int WDT_PERIOD_US   = 18000;
  localparam int OST_OSC_PERIODS = 1024;
  localparam int MCLK_MHZ        = 25;
  localparam int WDT_BASE_CYCLES = WDT_PERIOD_US * MCLK_MHZ;
  localparam int WDT_TICK_DIV    = 64;
  localparam int NUM_WAKE_SRC    = 10;
  localparam logic [13:0] IRQ_VECTOR = 14'h0004;

  typedef enum {WDSC_RUN, WDSC_SLEEP, WDSC_OST, WDSC_RESUME} wdsc_state_e;

  typedef struct packed {
    logic                    sleepInstr;
    logic                    clearInstr;
    logic [13:0]             pc;
  } wdsc_instr_s;

  typedef struct packed {
    logic        resetReq;
    logic        coreRun;
    logic        oscDriverOn;
    logic        vectorJump;
    logic [13:0] nextPc;
  } wdsc_core_s;
endpackage

// ### verilog/wdsc_watchdog_sleep.sv
// Watchdog timer with sleep entry, wake-up and timeout status control
// Behaviour
// - Watchdog counts on its own tick, also while core clock is off.
// - Timeout in normal operation requests a full device reset.
// - Timeout in sleep wakes the device instead of resetting it.
// - Config bit 2 cleared disables the watchdog until the config word is rewritten.
// - Base period 18 ms; prescaler up to 1:128 stretches the timeout.
// - Clear and sleep instructions reset counter and assigned prescaler.
// - After sleep executes, timeout cannot reset but can still wake.
// - Every timeout clears the active-low timeout flag.
// - Clear instruction zeroes prescaler count; assignment bit unchanged.
// - Sleep clears powerdown flag, sets timeout flag, stops oscillator.
// - Pins keep their pre-sleep drive state during sleep.
// - Master clear in sleep resets; watchdog or interrupt wake resumes.
// - Powerdown flag set at power-up, cleared on each sleep entry.
// - Only clockless peripherals may raise wake interrupts in sleep.
// - Wake needs the source enable bit, regardless of global enable.
// - After wake run next instruction, then vector 0004h if enabled.
// - Sleep prefetches the next sequential instruction.
// - Pending enabled interrupt before sleep makes sleep a no-op.
// - Interrupt during sleep completes sleep effects then wakes.
// - Crystal modes wait 1024 oscillator periods on wake; RC skips.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module wdsc_watchdog_sleep #(
  parameter int BASE_CYCLES = wdsc_pkg::WDT_BASE_CYCLES,
  parameter int OST_CYCLES  = wdsc_pkg::OST_OSC_PERIODS,
  parameter int NUM_SRC     = wdsc_pkg::NUM_WAKE_SRC,
  parameter int PIN_COUNT   = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   wdtOscTick,
  input  wire logic [13:0]            regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [7:0]             regRdata,
  input  wire wdsc_pkg::wdsc_instr_s  instr,
  input  wire logic                   masterClearPin,
  input  wire logic                   globalIrqEnable,
  input  wire logic [NUM_SRC-1:0]     irqFlag,
  input  wire logic [NUM_SRC-1:0]     sleepCapable,
  input  wire logic [PIN_COUNT-1:0]   pinOutIn,
  input  wire logic [PIN_COUNT-1:0]   pinOeIn,
  output logic      [PIN_COUNT-1:0]   pinOut,
  output logic      [PIN_COUNT-1:0]   pinOe,
  output wdsc_pkg::wdsc_core_s        core
);
  localparam int BCW = $clog2(BASE_CYCLES + 1);
  localparam int OCW = $clog2(OST_CYCLES + 1);

  logic [7:0]            optionReg;
  logic [7:0]            configReg;
  logic [NUM_SRC-1:0]    wakeEnable;
  logic                  timeoutFlagN;
  logic                  powerdownFlagN;
  logic [BCW-1:0]        baseCount;
  logic [6:0]            prescaleCount;
  logic                  baseExpire;
  logic                  wdtTimeout;
  logic                  wdtEnabled;
  logic                  wdtClear;
  logic                  irqWake;
  logic                  sleepTaken;
  logic                  sleepNop;
  logic [OCW-1:0]        ostCount;
  logic [PIN_COUNT-1:0]  heldOut;
  logic [PIN_COUNT-1:0]  heldOe;
  logic [13:0]           prefetchPc;
  logic                  resetPulse;
  logic                  vectorPending;
  logic [6:0]            prescaleLimit;
  logic [NUM_SRC-1:0]    srcWake;
  wdsc_pkg::wdsc_state_e state;
  wdsc_pkg::wdsc_state_e next_state;
  logic                  coreResetReq;
  logic                  coreRunning;
  logic                  oscOn;
  logic                  vectorJumpReg;
  logic [13:0]           resumePc;
  logic [7:0]            statusByte;

  assign wdtEnabled = configReg[wdsc_pkg::CFG_WDT_ENABLE_FUSE_BIT];

  // per-source enable qualifies wake; global enable ignored
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gWake
      // in sleep only clockless sources count
      assign srcWake[g] = irqFlag[g] & wakeEnable[g]
                          & ((state == wdsc_pkg::WDSC_RUN) | sleepCapable[g]);
    end
  endgenerate
  assign irqWake = |srcWake;

  // enabled interrupt already pending turns sleep into a no-op
  assign sleepNop   = instr.sleepInstr & (state == wdsc_pkg::WDSC_RUN)
                      & irqWake;
  assign sleepTaken = instr.sleepInstr & (state == wdsc_pkg::WDSC_RUN)
                      & ~sleepNop;

  // clear and sleep both restart the watchdog
  assign wdtClear = (instr.clearInstr & (state == wdsc_pkg::WDSC_RUN))
                    | sleepTaken;

  // assigned prescaler divides by 2^rate, else 1:1
  // Unassigned prescaler leaves the watchdog at one base period
  assign prescaleLimit = optionReg[wdsc_pkg::OPT_PSA_BIT]
                         ? 7'((8'h01 << optionReg[wdsc_pkg::OPT_RATE_LSB +:
                                                  wdsc_pkg::OPT_RATE_W])
                              - 8'h01) : 7'h00;

  // base counter advances on the watchdog oscillator tick only
  assign baseExpire = wdtOscTick & (baseCount == BCW'(BASE_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (rst || wdtClear || !wdtEnabled) begin
      baseCount <= '0;
    end else if (baseExpire) begin
      baseCount <= '0;
    end else if (wdtOscTick) begin
      baseCount <= baseCount + BCW'(1);
    end
  end

  // prescaler stretches timeout to up to 128 base periods
  // clear zeroes prescaler count without touching assignment
  always_ff @(posedge mclk) begin
    if (rst || wdtClear || !wdtEnabled) begin
      prescaleCount <= 7'h00;
    end else if (baseExpire) begin
      if (prescaleCount >= prescaleLimit) begin
        prescaleCount <= 7'h00;
      end else begin
        prescaleCount <= prescaleCount + 7'h01;
      end
    end
  end
  // A clear in the expiring cycle wins, so software never races the reset
  assign wdtTimeout = baseExpire & (prescaleCount >= prescaleLimit)
                      & wdtEnabled & ~wdtClear;

  // Option register answers at both bank addresses
  always_ff @(posedge mclk) begin
    if (rst) begin
      optionReg <= wdsc_pkg::OPTION_RESET;
    end else if (regWrite && (regAddr == wdsc_pkg::OPTION_ADDR ||
                              regAddr == wdsc_pkg::OPTION_ADDR2)) begin
      optionReg <= regWdata;
    end
  end

  // Wake enables; sources above bit 7 cannot be enabled over the 8-bit port
  always_ff @(posedge mclk) begin
    if (rst) begin
      wakeEnable <= NUM_SRC'(wdsc_pkg::WAKEEN_RESET);
    end else if (regWrite && regAddr == wdsc_pkg::WAKEEN_ADDR) begin
      wakeEnable <= NUM_SRC'(regWdata);
    end
  end

  // Fuse word survives core resets; only a write may change it
  // It powers up unknown, so software must program it before use
  always_ff @(posedge mclk) begin
    if (regWrite && regAddr == wdsc_pkg::CONFIG_ADDR) begin
      configReg <= regWdata;
    end
  end

  // timeout clears timeout flag; a sleep in the expiring cycle masks the timeout
  // sleep entry sets the timeout flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      timeoutFlagN <= 1'b1;
    end else if (wdtTimeout) begin
      timeoutFlagN <= 1'b0;
    end else if (sleepTaken || (instr.clearInstr &&
                 state == wdsc_pkg::WDSC_RUN)) begin
      timeoutFlagN <= 1'b1;
    end
  end

  // powerdown flag set at power-up, cleared on sleep entry
  always_ff @(posedge mclk) begin
    if (rst) begin
      powerdownFlagN <= 1'b1;
    end else if (sleepTaken) begin
      powerdownFlagN <= 1'b0;
    end else if (instr.clearInstr && state == wdsc_pkg::WDSC_RUN) begin
      powerdownFlagN <= 1'b1;
    end
  end

  // Sleep sequencer
  always_comb begin
    next_state = state;
    case (state)
      wdsc_pkg::WDSC_RUN: begin
        if (sleepTaken) begin
          next_state = wdsc_pkg::WDSC_SLEEP;
        end
      end
      // interrupt during sleep wakes after its effects
      wdsc_pkg::WDSC_SLEEP: begin
        if (wdtTimeout || irqWake) begin
          // RC mode skips the start-up wait
          if (configReg[wdsc_pkg::CFG_FOSC_LSB +: 2] == wdsc_pkg::FOSC_RC) begin
            next_state = wdsc_pkg::WDSC_RESUME;
          end else begin
            next_state = wdsc_pkg::WDSC_OST;
          end
        end
      end
      wdsc_pkg::WDSC_OST: begin
        if (ostCount == OCW'(OST_CYCLES - 1)) begin
          next_state = wdsc_pkg::WDSC_RESUME;
        end
      end
      wdsc_pkg::WDSC_RESUME: begin
        next_state = wdsc_pkg::WDSC_RUN;
      end
      default: begin
        next_state = wdsc_pkg::WDSC_RUN;
      end
    endcase
  end

  // master clear always resets, also from sleep
  // A watchdog reset also returns the sequencer to run
  always_ff @(posedge mclk) begin
    if (rst || masterClearPin || resetPulse) begin
      state <= wdsc_pkg::WDSC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // start-up wait of 1024 oscillator periods
  // Counts mclk cycles; the core clock stands in for the crystal here
  always_ff @(posedge mclk) begin
    if (rst || state != wdsc_pkg::WDSC_OST) begin
      ostCount <= '0;
    end else begin
      ostCount <= ostCount + OCW'(1);
    end
  end

  // no reset once sleep has executed
  // Registered so the reset request is one clean cycle long
  always_ff @(posedge mclk) begin
    if (rst) begin
      resetPulse <= 1'b0;
    end else begin
      resetPulse <= wdtTimeout & (state == wdsc_pkg::WDSC_RUN) & ~sleepTaken;
    end
  end

  // prefetch next instruction address while sleep executes
  always_ff @(posedge mclk) begin
    if (rst) begin
      prefetchPc <= 14'h0000;
    end else if (sleepTaken) begin
      prefetchPc <= instr.pc + 14'h0001;
    end
  end

  // vector after the prefetched instruction if global enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      vectorPending <= 1'b0;
    end else if (state == wdsc_pkg::WDSC_SLEEP && irqWake) begin
      vectorPending <= globalIrqEnable;
    end else if (state == wdsc_pkg::WDSC_SLEEP && wdtTimeout) begin
      vectorPending <= 1'b0;
    end
  end

  // capture pin drive on sleep entry and hold it
  // Capture runs every cycle in run so the image is current at entry
  always_ff @(posedge mclk) begin
    if (rst) begin
      heldOut <= '0;
      heldOe  <= '0;
    end else if (state == wdsc_pkg::WDSC_RUN) begin
      heldOut <= pinOutIn;
      heldOe  <= pinOeIn;
    end
  end
  assign pinOut = heldOut;
  assign pinOe  = heldOe;

  // watchdog reset pulse; master clear is passed on as a level
  always_ff @(posedge mclk) begin
    if (rst) begin
      coreResetReq <= 1'b0;
    end else begin
      coreResetReq <= resetPulse | masterClearPin;
    end
  end

  // Core runs from the same edge at which the sequencer returns to run, or one edge later after a master clear out of sleep
  always_ff @(posedge mclk) begin
    if (rst) begin
      coreRunning <= 1'b1;
    end else begin
      coreRunning <= (next_state == wdsc_pkg::WDSC_RUN);
    end
  end

  // oscillator driver off from sleep until start-up begins
  always_ff @(posedge mclk) begin
    if (rst) begin
      oscOn <= 1'b1;
    end else begin
      oscOn <= (next_state != wdsc_pkg::WDSC_SLEEP);
    end
  end

  // vector pulse on resume after an enabled interrupt wake
  always_ff @(posedge mclk) begin
    if (rst) begin
      vectorJumpReg <= 1'b0;
    end else begin
      vectorJumpReg <= (state == wdsc_pkg::WDSC_RESUME) & vectorPending;
    end
  end

  // resume address is the prefetched one unless vectoring
  always_ff @(posedge mclk) begin
    if (rst) begin
      resumePc <= 14'h0000;
    end else if (state == wdsc_pkg::WDSC_RESUME) begin
      resumePc <= vectorPending ? wdsc_pkg::IRQ_VECTOR : prefetchPc;
    end else begin
      resumePc <= prefetchPc;
    end
  end

  // Outputs are grouped for the core; every field comes from a flop
  assign core = '{resetReq: coreResetReq, coreRun: coreRunning,
                  oscDriverOn: oscOn, vectorJump: vectorJumpReg,
                  nextPc: resumePc};

  // Status image: only the two flags are implemented, the rest read 0
  always_comb begin
    statusByte = 8'h00;
    statusByte[wdsc_pkg::STAT_TO_BIT] = timeoutFlagN;
    statusByte[wdsc_pkg::STAT_PD_BIT] = powerdownFlagN;
  end

  // Read port: data one cycle after the strobe
  // Unmapped addresses and idle cycles read 0 so buses can be OR-ed
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        wdsc_pkg::OPTION_ADDR,
        wdsc_pkg::OPTION_ADDR2: regRdata <= optionReg;
        wdsc_pkg::CONFIG_ADDR:  regRdata <= configReg;
        wdsc_pkg::STATUS_ADDR:  regRdata <= statusByte;
        wdsc_pkg::WAKEEN_ADDR:  regRdata <= 8'(wakeEnable);
        wdsc_pkg::WAKEFLG_ADDR: regRdata <= 8'(srcWake);
        default:                regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// ### bench/wdsc_props.sv
// Port checker for the watchdog and sleep control block
`timescale 1ns/1ns
module wdsc_props #(
  parameter int NUM_SRC   = 10,
  parameter int PIN_COUNT = 8
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  regRead,
  input wire logic [7:0]            regRdata,
  input wire wdsc_pkg::wdsc_instr_s instr,
  input wire logic                  masterClearPin,
  input wire logic                  globalIrqEnable,
  input wire logic [NUM_SRC-1:0]    irqFlag,
  input wire logic [PIN_COUNT-1:0]  pinOutIn,
  input wire logic [PIN_COUNT-1:0]  pinOeIn,
  input wire logic [PIN_COUNT-1:0]  pinOut,
  input wire logic [PIN_COUNT-1:0]  pinOe,
  input wire wdsc_pkg::wdsc_core_s  core
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence sleepGo;
    core.coreRun && instr.sleepInstr && irqFlag == '0 && !masterClearPin;
  endsequence
  sequence asleep;
    !core.coreRun && !core.oscDriverOn;
  endsequence
  AST_SLEEP_ENTRY: assert property (sleepGo |=> asleep)
    else $error("sleep entry did not stop core and oscillator");
  AST_PINS_FROZEN: assert property (asleep ##1 asleep |->
    $stable(pinOut) && $stable(pinOe)) else $error("pins moved in sleep");
  AST_PINS_FOLLOW: assert property (
    (core.coreRun && !instr.sleepInstr && !masterClearPin) |=>
    pinOut == $past(pinOutIn) && pinOe == $past(pinOeIn))
    else $error("pins not following in run");
  AST_MASTER_CLEAR_PIN: assert property (masterClearPin |=> core.resetReq)
    else $error("master clear gave no reset");
  AST_RST_PULSE: assert property ((core.resetReq &&
    !$past(masterClearPin) && !masterClearPin) |=> !core.resetReq)
    else $error("watchdog reset longer than one cycle");
  AST_NO_RST_ASLEEP: assert property ((!core.coreRun &&
    !$past(core.coreRun) && !$past(masterClearPin)) |-> !core.resetReq)
    else $error("reset request while asleep");
  AST_VECTOR: assert property (core.vectorJump |->
    core.nextPc == wdsc_pkg::IRQ_VECTOR && $past(globalIrqEnable))
    else $error("vector jump wrong");
  AST_READ_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside read answer");
  AST_OSC_RUN: assert property (core.coreRun |-> core.oscDriverOn)
    else $error("oscillator off while running");
endmodule

bind wdsc_watchdog_sleep wdsc_props #(.NUM_SRC(NUM_SRC),
  .PIN_COUNT(PIN_COUNT)) props_u (.*);

// ### bench/wdsc_watchdog_sleep_tb_top.sv
// Self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ns
module wdsc_watchdog_sleep_tb_top;
  localparam int BASE = 4;
  localparam int OST  = 4;
  logic                  mclk, rst, tick, wr, rd, mclrPin, global_irq_enable;
  logic [13:0]           addr;
  logic [7:0]            wdata, rdata, got, pinIn, oeIn, pinOut, pinOe;
  logic [9:0]            irq, sleepCap;
  wdsc_pkg::wdsc_instr_s instr;
  wdsc_pkg::wdsc_core_s  core;
  int                    fail_count, check_count, rstSeen, n1, n2;
  wdsc_watchdog_sleep #(.BASE_CYCLES(BASE), .OST_CYCLES(OST)) dut_u (
    .mclk(mclk), .rst(rst), .wdtOscTick(tick), .regAddr(addr),
    .regWdata(wdata), .regWrite(wr), .regRead(rd), .regRdata(rdata),
    .instr(instr), .masterClearPin(mclrPin), .globalIrqEnable(global_irq_enable),
    .irqFlag(irq), .sleepCapable(sleepCap), .pinOutIn(pinIn),
    .pinOeIn(oeIn), .pinOut(pinOut), .pinOe(pinOe), .core(core));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (core.resetReq === 1'b1) rstSeen++;
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrReg(input logic [13:0] a, input logic [7:0] d);
    @(posedge mclk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [13:0] a);
    @(posedge mclk);
    {addr, rd} <= {a, 1'b1};
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Checks timeout and powerdown flags as {bit4, bit3}
  task automatic stat(input logic [1:0] e);
    rdReg(wdsc_pkg::STATUS_ADDR);
    chk(16'(got[4:3]), 16'(e));
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
    end
  endtask
  // Sleep when s is set, watchdog clear otherwise
  task automatic op(input logic s);
    @(posedge mclk);
    instr <= '{sleepInstr: s, clearInstr: !s, pc: 14'h0123};
    @(posedge mclk);
    instr <= '{sleepInstr: 1'b0, clearInstr: 1'b0, pc: 14'h0123};
    #1;
  endtask
  task automatic waitRun(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (core.coreRun !== 1'b1 && n < 200);
  endtask
  task automatic wdtRun();
    wrReg(wdsc_pkg::OPTION_ADDR, 8'h00);
    op(1'b0);
    rstSeen = 0;
    ticks(BASE - 1);
    op(1'b0);
    ticks(BASE - 1);
    chk(16'(rstSeen), 16'h0);
    ticks(1);
    repeat (5) @(posedge mclk);
    chk(16'(rstSeen), 16'h1);
    stat(2'b01);
  endtask
  // Half-filled prescaler must be zeroed by the clear
  task automatic wdtPrescale();
    wrReg(wdsc_pkg::OPTION_ADDR2, 8'h09);
    op(1'b0);
    ticks(BASE);
    op(1'b0);
    rstSeen = 0;
    ticks(2 * BASE - 1);
    chk(16'(rstSeen), 16'h0);
    ticks(1);
    repeat (5) @(posedge mclk);
    chk(16'(rstSeen), 16'h1);
    rdReg(wdsc_pkg::OPTION_ADDR);
    chk(16'(got), 16'h0009);
  endtask
  task automatic wdtWake();
    wrReg(wdsc_pkg::OPTION_ADDR, 8'h00);
    wrReg(wdsc_pkg::WAKEEN_ADDR, 8'h00);
    op(1'b0);
    op(1'b1);
    rstSeen = 0;
    chk(16'({core.coreRun, core.oscDriverOn}), 16'h0);
    stat(2'b10);
    @(posedge mclk);
    {pinIn, oeIn} <= 16'h5a0f;
    repeat (2) @(posedge mclk);
    #1 chk({pinOut, pinOe}, 16'ha5f0);
    ticks(BASE);
    waitRun(n1);
    chk(16'(rstSeen), 16'h0);
    chk(16'(core.nextPc), 16'h0124);
    stat(2'b00);
  endtask
  task automatic irqWake(input logic g, input logic [7:0] cfg,
                         output int n);
    wrReg(wdsc_pkg::CONFIG_ADDR, cfg);
    wrReg(wdsc_pkg::WAKEEN_ADDR, 8'h01);
    op(1'b0);
    op(1'b1);
    @(posedge mclk);
    {irq, sleepCap, global_irq_enable} <= {10'h003, 10'h3fe, g};
    repeat (10) @(posedge mclk);
    #1 chk(16'(core.coreRun), 16'h0);
    @(posedge mclk);
    sleepCap <= 10'h3ff;
    waitRun(n);
    chk(16'(core.vectorJump), 16'(g));
    chk(16'(core.nextPc), g ? 16'h0004 : 16'h0124);
    stat(2'b10);
    @(posedge mclk);
    {irq, global_irq_enable} <= '0;
  endtask
  task automatic sleepPending();
    @(posedge mclk);
    irq <= 10'h001;
    op(1'b0);
    op(1'b1);
    chk(16'(core.coreRun), 16'h1);
    stat(2'b11);
    @(posedge mclk);
    irq <= 10'h000;
  endtask
  task automatic sleepMclr();
    op(1'b1);
    @(posedge mclk);
    mclrPin <= 1'b1;
    @(posedge mclk);
    #1 chk(16'(core.resetReq), 16'h1);
    @(posedge mclk);
    mclrPin <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic fuseOff();
    wrReg(wdsc_pkg::CONFIG_ADDR, 8'hfb);
    wrReg(wdsc_pkg::OPTION_ADDR, 8'h00);
    op(1'b0);
    rstSeen = 0;
    ticks(3 * BASE);
    repeat (5) @(posedge mclk);
    chk(16'(rstSeen), 16'h0);
  endtask
  initial begin
    {tick, wr, rd, mclrPin, global_irq_enable, rst} = 6'h01;
    {addr, wdata, irq, instr} = '0;
    {sleepCap, pinIn, oeIn} = {10'h3ff, 8'ha5, 8'hf0};
    {fail_count, check_count, rstSeen} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdReg(wdsc_pkg::OPTION_ADDR);
    chk(16'(got), 16'(wdsc_pkg::OPTION_RESET));
    rdReg(14'h0050);
    chk(16'(got), 16'h0000);
    stat(2'b11);
    wrReg(wdsc_pkg::CONFIG_ADDR, 8'hfe);
    wdtRun();
    wdtPrescale();
    wdtWake();
    irqWake(1'b1, 8'hfe, n1);
    irqWake(1'b0, 8'hff, n2);
    chk(16'(n1 - n2), 16'(OST));
    sleepPending();
    sleepMclr();
    fuseOff();
    test_done();
  end
  // Tests need a few hundred cycles; this span is far beyond that
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
endmodule
